// File: ptc_clock_ctrl.sv
// Precision time clock: control register, time registers and the running clock
`timescale 1ns/1ps
`default_nettype none
module ptc_clock_ctrl (
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire ptc_pkg::ptc_req_s    reg_req,    // Host register request
  output logic               [15:0] reg_rdata,  // Read data, one cycle after rd
  output ptc_pkg::ptc_time_s        live_time,  // Running clock
  output logic                [2:0] live_phase  // Running 8 ns slot
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [6:0]  ctl_q, ctl_d;          // Clock control bits 6..0
  logic [15:0] ns_low_q, ns_low_d;    // Nanoseconds [15:0]
  logic [13:0] ns_high_q, ns_high_d;  // Nanoseconds [29:16]
  logic [15:0] sec_low_q, sec_low_d;  // Seconds [15:0]
  logic [15:0] sec_high_q, sec_high_d;// Seconds [31:16]
  logic [2:0]  phase_q, phase_d;      // Sub-phase slot
  logic [15:0] rate_low_q, rate_low_d;// Rate [15:0]
  logic [14:0] rate_high_q, rate_high_d; // Rate sign and [29:16]
  logic [15:0] rdata_q, rdata_d;      // Read data holding register
  ptc_pkg::ptc_time_s time_q, time_d; // Running clock

  // Decoded writes
  logic        wr_ctl, wr_ns_low, wr_ns_high, wr_sec_low, wr_sec_high;
  logic        wr_phase, wr_rate_low, wr_rate_high, wr_time_reg;

  // Actions and modes this cycle, taken from the stored go and mode bits
  logic        do_reset, do_load, do_capture, do_step, run_en, cont_en;
  logic [29:0] rate_val;
  logic [29:0] step_ns;
  logic [1:0]  ticks;
  logic [2:0]  slot;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Add an increment in ns.frac form and wrap nanoseconds into seconds
  // Limitation: one wrap only, so a step of a second or more can leave
  // nanoseconds out of range for one cycle, until the next add wraps them
  function automatic ptc_pkg::ptc_time_s time_add(ptc_pkg::ptc_time_s t, logic [61:0] inc);
    logic [62:0] sum;
    ptc_pkg::ptc_time_s r;
    sum = {1'b0, t.ns, t.frac} + {1'b0, inc};
    r   = t;
    if (sum[62:32] >= {1'b0, ptc_pkg::NS_PER_SEC}) begin
      sum   = sum - {1'b0, ptc_pkg::NS_PER_SEC, 32'h00000000};
      r.sec = t.sec + 32'h00000001;
    end
    r.ns   = sum[61:32];
    r.frac = sum[31:0];
    return r;
  endfunction : time_add

  // Subtract whole nanoseconds, borrowing from seconds when needed
  // One borrow only; a backward step of a full second or more is not
  // folded, which keeps the path short at the cost of range
  function automatic ptc_pkg::ptc_time_s time_sub(ptc_pkg::ptc_time_s t, logic [29:0] v);
    logic [30:0] diff;
    ptc_pkg::ptc_time_s r;
    diff = {1'b0, t.ns} - {1'b0, v};
    r    = t;
    if (diff[30]) begin
      diff  = diff + {1'b0, ptc_pkg::NS_PER_SEC};
      r.sec = t.sec - 32'h00000001;
    end
    r.ns = diff[29:0];
    return r;
  endfunction : time_sub

  // ==========================================================================
  // Address decode
  // ==========================================================================
  // Only full 16-bit words are decoded; odd offsets hit nothing
  always_comb begin
    wr_ctl       = reg_req.wr && (reg_req.addr == ptc_pkg::ADDR_CLOCK_CONTROL);
    wr_ns_low    = reg_req.wr && (reg_req.addr == ptc_pkg::ADDR_NS_LOW);
    wr_ns_high   = reg_req.wr && (reg_req.addr == ptc_pkg::ADDR_NS_HIGH);
    wr_sec_low   = reg_req.wr && (reg_req.addr == ptc_pkg::ADDR_SEC_LOW);
    wr_sec_high  = reg_req.wr && (reg_req.addr == ptc_pkg::ADDR_SEC_HIGH);
    wr_phase     = reg_req.wr && (reg_req.addr == ptc_pkg::ADDR_SUB_PHASE);
    wr_rate_low  = reg_req.wr && (reg_req.addr == ptc_pkg::ADDR_RATE_LOW);
    wr_rate_high = reg_req.wr && (reg_req.addr == ptc_pkg::ADDR_RATE_HIGH);
    wr_time_reg  = wr_ns_low || wr_ns_high || wr_sec_low || wr_sec_high;
  end

  // ==========================================================================
  // Control decode
  // ==========================================================================
  // Go bits act in the cycle after the write that set them
  // A go bit reads back as one only in that single cycle
  always_comb begin
    do_reset   = ctl_q[ptc_pkg::CTL_CLOCK_RESET_GO];
    do_load    = ctl_q[ptc_pkg::CTL_LOAD_TIME_GO];
    do_capture = ctl_q[ptc_pkg::CTL_CAPTURE_TIME_GO];
    do_step    = ctl_q[ptc_pkg::CTL_STEP_ADJUST_GO];
    run_en     = ctl_q[ptc_pkg::CTL_CLOCK_RUN_EN];
    rate_val   = {rate_high_q[ptc_pkg::RATE_HIGH_BITS-1:0], rate_low_q};
    // A zero rate turns adjustment off whatever the mode bit says
    cont_en    = ctl_q[ptc_pkg::CTL_CONT_RATE_EN] && (rate_val != 30'h00000000);
    step_ns    = {ns_high_q, ns_low_q};
  end

  // ==========================================================================
  // Reference-cycle sequencer
  // ==========================================================================
  // Frozen together with the clock so the sub-phase stays meaningful
  // Load resumes from the phase word so slot and time stay in step
  ptc_ref_tick u_ref_tick (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .run_en    (run_en),
    .clear     (do_reset),
    .load_en   (do_load),
    .load_slot (phase_q),
    .ticks     (ticks),
    .slot      (slot)
  );

  // ==========================================================================
  // Running clock
  // ==========================================================================
  // Priority: reset, then load, then normal advance plus any step
  // Step follows the advance so neither is lost in a shared cycle
  always_comb begin
    logic [61:0] per_tick;
    logic [61:0] inc;
    per_tick = {30'(ptc_pkg::REF_PERIOD_NS), 32'h00000000};
    inc      = 62'h0;
    time_d   = time_q;
    // Increment per reference cycle is 40 ns moved by the rate
    if (cont_en) begin
      if (rate_high_q[ptc_pkg::RATE_SIGN_POS-1]) begin
        per_tick = per_tick - {32'h00000000, rate_val};
      end else begin
        per_tick = per_tick + {32'h00000000, rate_val};
      end
    end
    if (ticks == 2'h2) begin
      inc = {per_tick[60:0], 1'b0};
    end else if (ticks == 2'h1) begin
      inc = per_tick;
    end
    if (do_reset) begin
      time_d = '0;
    end else if (do_load) begin
      // Sub-nanoseconds restart from zero on a direct setting
      time_d = '{sec: {sec_high_q, sec_low_q}, ns: step_ns, frac: 32'h00000000};
    end else begin
      // No ticks while frozen, so the value holds
      time_d = time_add(time_q, inc);
      if (do_step) begin
        if (ctl_q[ptc_pkg::CTL_STEP_SIGN]) begin
          time_d = time_add(time_d, {step_ns, 32'h00000000});
        end else begin
          time_d = time_sub(time_d, step_ns);
        end
      end
    end
  end

  // Clock register
  // Synchronous reset only; the clock restarts at zero with run enabled
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      time_q <= '0;
    end else begin
      time_q <= time_d;
    end
  end

  // ==========================================================================
  // Host registers
  // ==========================================================================
  // Capture lands first; a software write in the same cycle overrides it
  // Captured words come from the registered clock, one cycle after the go bit
  always_comb begin
    ctl_d       = ctl_q & ~ptc_pkg::CTL_SELF_CLEAR_MASK;
    ns_low_d    = ns_low_q;
    ns_high_d   = ns_high_q;
    sec_low_d   = sec_low_q;
    sec_high_d  = sec_high_q;
    phase_d     = phase_q;
    rate_low_d  = rate_low_q;
    rate_high_d = rate_high_q;
    if (do_capture) begin
      ns_low_d   = time_q.ns[15:0];
      ns_high_d  = time_q.ns[29:16];
      sec_low_d  = time_q.sec[15:0];
      sec_high_d = time_q.sec[31:16];
      phase_d    = slot;
    end
    // A fresh write of a go bit wins over its self-clear
    if (wr_ctl) begin
      ctl_d = reg_req.wdata[ptc_pkg::CTL_WIDTH-1:0];
    end
    if (wr_ns_low) begin
      ns_low_d = reg_req.wdata;
    end
    if (wr_ns_high) begin
      ns_high_d = reg_req.wdata[ptc_pkg::NS_HIGH_BITS-1:0];
    end
    if (wr_sec_low) begin
      sec_low_d = reg_req.wdata;
    end
    if (wr_sec_high) begin
      sec_high_d = reg_req.wdata;
    end
    if (wr_phase) begin
      phase_d = reg_req.wdata[ptc_pkg::PHASE_BITS-1:0];
    end
    // Time word writes make any held sub-phase stale
    if (wr_time_reg) begin
      phase_d = ptc_pkg::PHASE_RESET;
    end
    if (wr_rate_low) begin
      rate_low_d = reg_req.wdata;
    end
    if (wr_rate_high) begin
      rate_high_d = {reg_req.wdata[ptc_pkg::RATE_SIGN_POS], reg_req.wdata[ptc_pkg::RATE_HIGH_BITS-1:0]};
    end
  end

  // Host register bank
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctl_q       <= ptc_pkg::CTL_RESET;
      ns_low_q    <= ptc_pkg::NS_LOW_RESET;
      ns_high_q   <= ptc_pkg::NS_HIGH_RESET;
      sec_low_q   <= ptc_pkg::SEC_WORD_RESET;
      sec_high_q  <= ptc_pkg::SEC_WORD_RESET;
      phase_q     <= ptc_pkg::PHASE_RESET;
      rate_low_q  <= ptc_pkg::RATE_LOW_RESET;
      rate_high_q <= ptc_pkg::RATE_HIGH_RESET;
    end else begin
      ctl_q       <= ctl_d;
      ns_low_q    <= ns_low_d;
      ns_high_q   <= ns_high_d;
      sec_low_q   <= sec_low_d;
      sec_high_q  <= sec_high_d;
      phase_q     <= phase_d;
      rate_low_q  <= rate_low_d;
      rate_high_q <= rate_high_d;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  // Reserved bits and unmapped offsets read as zero
  // Registered read data eases host timing at the cost of one cycle
  always_comb begin
    rdata_d = rdata_q;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        ptc_pkg::ADDR_CLOCK_CONTROL: rdata_d = {9'h000, ctl_q};
        ptc_pkg::ADDR_NS_LOW:        rdata_d = ns_low_q;
        ptc_pkg::ADDR_NS_HIGH:       rdata_d = {2'h0, ns_high_q};
        ptc_pkg::ADDR_SEC_LOW:       rdata_d = sec_low_q;
        ptc_pkg::ADDR_SEC_HIGH:      rdata_d = sec_high_q;
        ptc_pkg::ADDR_SUB_PHASE:     rdata_d = {13'h0000, phase_q};
        ptc_pkg::ADDR_RATE_LOW:      rdata_d = rate_low_q;
        ptc_pkg::ADDR_RATE_HIGH:     rdata_d = {rate_high_q[14], 1'b0, rate_high_q[13:0]};
        default:                     rdata_d = 16'h0000;
      endcase
    end
  end

  // Read data register; holds until the next read
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign live_time  = time_q;
  assign live_phase = slot;

endmodule : ptc_clock_ctrl
`default_nettype wire

// File: ptc_pkg.sv
// Shared constants and carrier types for the precision time clock control block
package ptc_pkg;

  // ==========================================================================
  // Register byte offsets on the 16-bit host register port
  // ==========================================================================
  localparam logic [11:0] ADDR_CLOCK_CONTROL = 12'h600;  // Clock control
  localparam logic [11:0] ADDR_NS_LOW        = 12'h604;  // Nanoseconds [15:0]
  localparam logic [11:0] ADDR_NS_HIGH       = 12'h606;  // Nanoseconds [29:16]
  localparam logic [11:0] ADDR_SEC_LOW       = 12'h608;  // Seconds [15:0]
  localparam logic [11:0] ADDR_SEC_HIGH      = 12'h60A;  // Seconds [31:16]
  localparam logic [11:0] ADDR_SUB_PHASE     = 12'h60C;  // 8 ns slot in 40 ns
  localparam logic [11:0] ADDR_RATE_LOW      = 12'h610;  // Rate [15:0]
  localparam logic [11:0] ADDR_RATE_HIGH     = 12'h612;  // Rate [29:16] and sign

  // ==========================================================================
  // Clock control field positions and reset value
  // ==========================================================================
  localparam int unsigned CTL_CLOCK_RESET_GO  = 0;
  localparam int unsigned CTL_CLOCK_RUN_EN    = 1;
  localparam int unsigned CTL_CONT_RATE_EN    = 2;
  localparam int unsigned CTL_LOAD_TIME_GO    = 3;
  localparam int unsigned CTL_CAPTURE_TIME_GO = 4;
  localparam int unsigned CTL_STEP_SIGN       = 5;
  localparam int unsigned CTL_STEP_ADJUST_GO  = 6;
  localparam int unsigned CTL_WIDTH           = 7;   // Bits 15..7 reserved
  localparam logic [6:0]  CTL_RESET           = 7'h02;
  localparam logic [6:0]  CTL_SELF_CLEAR_MASK = 7'h59;

  // Rate high word fields
  localparam int unsigned RATE_HIGH_BITS      = 14;  // Rate bits [29:16]
  localparam int unsigned RATE_SIGN_POS       = 15;  // 1 = lower the increment
  localparam int unsigned NS_HIGH_BITS        = 14;  // Nanoseconds bits [29:16]
  localparam int unsigned PHASE_BITS          = 3;

  // Register reset values
  localparam logic [15:0] NS_LOW_RESET        = 16'h0000;
  localparam logic [13:0] NS_HIGH_RESET       = 14'h0000;
  localparam logic [15:0] SEC_WORD_RESET      = 16'h0000;
  localparam logic [2:0]  PHASE_RESET         = 3'h0;
  localparam logic [15:0] RATE_LOW_RESET      = 16'h0000;
  localparam logic [14:0] RATE_HIGH_RESET     = 15'h0000;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned SYS_PERIOD_NS  = 50;          // 20 MHz system clock
  localparam int unsigned REF_PERIOD_NS  = 40;          // 25 MHz reference cycle
  localparam int unsigned SLOT_NS        = 8;           // Sub-phase resolution
  localparam int unsigned SLOT_LAST      = REF_PERIOD_NS / SLOT_NS - 1;
  localparam logic [29:0] NS_PER_SEC     = 30'h3B9ACA00;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic [31:0] sec;   // Seconds count
    logic [29:0] ns;    // Nanoseconds within the second
    logic [31:0] frac;  // Sub-nanoseconds, units of 2^-32 ns
  } ptc_time_s;

  typedef struct packed {
    logic        wr;     // Write strobe, one cycle
    logic        rd;     // Read strobe, one cycle
    logic [11:0] addr;   // Byte offset, even
    logic [15:0] wdata;  // Write data
  } ptc_req_s;

endpackage : ptc_pkg

// File: ptc_ref_tick.sv
// Reference-cycle sequencer: 25 MHz update ticks and 8 ns slot seen from sys_clk
`timescale 1ns/1ps
`default_nettype none
module ptc_ref_tick (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       run_en,     // Advance the sequence
  input  wire logic       clear,      // Back to slot 0
  input  wire logic       load_en,    // Take load_slot
  input  wire logic [2:0] load_slot,  // Slot to resume from
  output logic      [1:0] ticks,      // Reference cycles in this sys cycle
  output logic      [2:0] slot        // Current 8 ns slot
);

  // ==========================================================================
  // Offset of sys_clk inside the current 40 ns reference cycle
  // ==========================================================================
  logic [5:0] off_q;  // 0..39 ns
  logic [5:0] off_d;
  logic [6:0] sum;    // Offset plus one sys period

  // Next offset; 50 ns always spans one or two reference cycles
  always_comb begin
    sum   = {1'b0, off_q} + 7'(ptc_pkg::SYS_PERIOD_NS);
    ticks = 2'h0;
    off_d = off_q;
    if (clear) begin
      off_d = 6'h00;
    end else if (load_en) begin
      // Slots above the last one are meaningless; treat them as slot 0
      off_d = (load_slot > 3'(ptc_pkg::SLOT_LAST)) ? 6'h00 : 6'(load_slot) * 6'(ptc_pkg::SLOT_NS);
    end else if (run_en) begin
      if (sum >= 7'(2 * ptc_pkg::REF_PERIOD_NS)) begin
        ticks = 2'h2;
        off_d = 6'(sum - 7'(2 * ptc_pkg::REF_PERIOD_NS));
      end else begin
        ticks = 2'h1;
        off_d = 6'(sum - 7'(ptc_pkg::REF_PERIOD_NS));
      end
    end
  end

  // Offset register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      off_q <= 6'h00;
    end else begin
      off_q <= off_d;
    end
  end

  // Slot index; from reset only slots 0..3 are seen at 50 ns sampling, but a loaded slot can also bring up slot 4
  assign slot = 3'(off_q / 6'(ptc_pkg::SLOT_NS));

endmodule : ptc_ref_tick
`default_nettype wire

// File: ptc_clock_ctrl_assertions.sv
// Assertion checker for the precision time clock control block
`timescale 1ns/1ps
`default_nettype none
module ptc_clock_ctrl_checker (
  input wire logic               sys_clk,
  input wire logic               nrst,
  input wire ptc_pkg::ptc_req_s  reg_req,
  input wire logic        [15:0] reg_rdata,
  input wire ptc_pkg::ptc_time_s live_time,
  input wire logic         [2:0] live_phase
);
  // ==========================================================================
  // Request decodes
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic ctl_wr;     // Write to the control word
  logic go_wr;      // Control write that sets a go bit
  logic frz_wr;     // Control write that stops the clock, no reset, load or step go bit
  logic time_wr;    // Write to any seconds or nanosecond word
  logic mapped;     // Address hits a register
  assign ctl_wr  = reg_req.wr && reg_req.addr == ptc_pkg::ADDR_CLOCK_CONTROL;
  assign go_wr   = ctl_wr && (reg_req.wdata[6:0] & ptc_pkg::CTL_SELF_CLEAR_MASK) != 7'h00;
  // Bits 0, 1, 3 and 6 all zero: nothing may move the clock
  assign frz_wr  = ctl_wr && (reg_req.wdata[6:0] & 7'h4B) == 7'h00;
  assign time_wr = reg_req.wr && reg_req.addr inside {ptc_pkg::ADDR_NS_LOW, ptc_pkg::ADDR_NS_HIGH,
                                                      ptc_pkg::ADDR_SEC_LOW, ptc_pkg::ADDR_SEC_HIGH};
  assign mapped  = reg_req.addr inside {ptc_pkg::ADDR_CLOCK_CONTROL, ptc_pkg::ADDR_NS_LOW,
                   ptc_pkg::ADDR_NS_HIGH, ptc_pkg::ADDR_SEC_LOW, ptc_pkg::ADDR_SEC_HIGH,
                   ptc_pkg::ADDR_SUB_PHASE, ptc_pkg::ADDR_RATE_LOW, ptc_pkg::ADDR_RATE_HIGH};

  // ==========================================================================
  // Properties
  // ==========================================================================
  a_reset_clock_zero: assert property ($rose(nrst) |-> live_time == '0 && live_phase == 3'h0)
    else $error("clock not zero after reset");
  a_ctl_reserved_zero: assert property (reg_req.rd && reg_req.addr == ptc_pkg::ADDR_CLOCK_CONTROL
    |=> reg_rdata[15:7] == 9'h000) else $error("control reserved bits not zero");
  a_nsh_top_zero: assert property (reg_req.rd && reg_req.addr == ptc_pkg::ADDR_NS_HIGH
    |=> reg_rdata[15:14] == 2'h0) else $error("ns high top bits not zero");
  a_unmapped_zero: assert property (reg_req.rd && !mapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_go_self_clear: assert property (go_wr ##1 !ctl_wr ##1 reg_req.rd && reg_req.addr == ptc_pkg::ADDR_CLOCK_CONTROL
    |=> (reg_rdata[6:0] & ptc_pkg::CTL_SELF_CLEAR_MASK) == 7'h00) else $error("go bit did not clear");
  a_freeze_holds: assert property (frz_wr |=> ##1 $stable(live_time))
    else $error("frozen clock moved");
  a_phase_cleared: assert property (time_wr ##1 reg_req.rd && reg_req.addr == ptc_pkg::ADDR_SUB_PHASE
    |=> reg_rdata == 16'h0000) else $error("phase not cleared by time write");
  a_capture_copy: assert property (ctl_wr && reg_req.wdata[4] ##1 !reg_req.wr
    ##1 reg_req.rd && reg_req.addr == ptc_pkg::ADDR_NS_LOW |=> reg_rdata == $past(live_time.ns[15:0], 2))
    else $error("capture did not copy the clock");

  // Main scenarios reached
  c_go_write: cover property (go_wr);
  c_freeze: cover property (frz_wr);
  c_phase_clear: cover property (time_wr ##1 reg_req.rd && reg_req.addr == ptc_pkg::ADDR_SUB_PHASE);
endmodule : ptc_clock_ctrl_checker

bind ptc_clock_ctrl ptc_clock_ctrl_checker u_chk (.sys_clk(sys_clk), .nrst(nrst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .live_time(live_time), .live_phase(live_phase));
`default_nettype wire

// File: testbench.sv
// Self-checking testbench for the precision time clock control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========================================================================
  // Signals and design
  // ==========================================================================
  logic               sys_clk;
  logic               nrst;
  ptc_pkg::ptc_req_s  reg_req;
  logic        [15:0] reg_rdata;
  ptc_pkg::ptc_time_s live_time;
  logic         [2:0] live_phase;
  int                 mismatches = 0;
  int                 checked = 0;
  int                 cycles = 0;
  logic        [15:0] rd_val;      // Last word read
  logic        [63:0] t0;          // Snapshot of {ns, frac}
  logic        [11:0] ra [8];      // Register offsets
  logic        [15:0] rv [8];      // Their reset values

  ptc_clock_ctrl u_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
                        .live_time(live_time), .live_phase(live_phase));

  // 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Hang guard: the run needs under a hundred cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      stop_test();
    end
  end

  // ==========================================================================
  // Access tasks
  // ==========================================================================
  // Request stands for exactly one edge; caller issues idle before pausing
  task automatic op(input logic w, input logic r, input logic [11:0] a, input logic [15:0] d);
    reg_req = '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge sys_clk);
    #2;
  endtask : op

  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    op(1'b1, 1'b0, a, d);
  endtask : wr_reg

  task automatic idle(input int n);
    reg_req = '0;
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : idle

  task automatic chk(input string n, input logic [95:0] e, input logic [95:0] g);
    checked = checked + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Read data lands on the edge that takes the read
  task automatic rchk(input string n, input logic [11:0] a, input logic [15:0] e);
    op(1'b0, 1'b1, a, 16'h0000);
    rd_val = reg_rdata;
    chk(n, {80'h0, e}, {80'h0, rd_val});
  endtask : rchk

  // Four edges always hold five reference ticks, whatever the slot
  task automatic adv(input logic [63:0] e);
    idle(1);
    t0 = {2'h0, live_time.ns, live_time.frac};
    idle(4);
    chk("advance", {32'h0, e}, {32'h0, {2'h0, live_time.ns, live_time.frac} - t0});
  endtask : adv

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    nrst = 1'b0;
    reg_req = '0;
    ra = '{ptc_pkg::ADDR_CLOCK_CONTROL, ptc_pkg::ADDR_NS_LOW, ptc_pkg::ADDR_NS_HIGH, ptc_pkg::ADDR_SEC_LOW,
           ptc_pkg::ADDR_SEC_HIGH, ptc_pkg::ADDR_SUB_PHASE, ptc_pkg::ADDR_RATE_LOW, ptc_pkg::ADDR_RATE_HIGH};
    rv = '{16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    repeat (4) @(posedge sys_clk);
    #2;
    nrst = 1'b1;
    // Reset values, then gaps and odd offsets that must read zero
    for (int i = 0; i < 8; i++) rchk("reset_value", ra[i], rv[i]);
    wr_reg(12'h602, 16'hFFFF);
    rchk("gap_602", 12'h602, 16'h0000);
    rchk("odd_605", 12'h605, 16'h0000);
    $display("test reset_values done");
    // Read-write words and reserved bits
    wr_reg(ptc_pkg::ADDR_NS_LOW, 16'hA5C3);
    wr_reg(ptc_pkg::ADDR_NS_HIGH, 16'hFFFF);
    wr_reg(ptc_pkg::ADDR_SEC_LOW, 16'h1234);
    wr_reg(ptc_pkg::ADDR_SEC_HIGH, 16'hBEEF);
    wr_reg(ptc_pkg::ADDR_CLOCK_CONTROL, 16'hFFA4);
    rchk("ns_low", ptc_pkg::ADDR_NS_LOW, 16'hA5C3);
    rchk("ns_high", ptc_pkg::ADDR_NS_HIGH, 16'h3FFF);
    rchk("sec_low", ptc_pkg::ADDR_SEC_LOW, 16'h1234);
    rchk("sec_high", ptc_pkg::ADDR_SEC_HIGH, 16'hBEEF);
    rchk("control", ptc_pkg::ADDR_CLOCK_CONTROL, 16'h0024);
    $display("test register_access done");
    // Load just below a second boundary, clock stopped so values are exact
    wr_reg(ptc_pkg::ADDR_SEC_LOW, 16'h0005);
    wr_reg(ptc_pkg::ADDR_SEC_HIGH, 16'h0000);
    wr_reg(ptc_pkg::ADDR_NS_HIGH, 16'h3B9A);
    wr_reg(ptc_pkg::ADDR_NS_LOW, 16'hC99C);
    wr_reg(ptc_pkg::ADDR_SUB_PHASE, 16'h0002);
    wr_reg(ptc_pkg::ADDR_CLOCK_CONTROL, 16'h0008);
    idle(1);
    chk("load", {2'h0, 32'h5, 30'h3B9AC99C, 32'h0}, {2'h0, live_time});
    chk("load_phase", 96'h2, {93'h0, live_phase});
    // Spoil the words, then capture brings the clock back into them
    wr_reg(ptc_pkg::ADDR_NS_LOW, 16'h0000);
    wr_reg(ptc_pkg::ADDR_SEC_LOW, 16'h0000);
    wr_reg(ptc_pkg::ADDR_CLOCK_CONTROL, 16'h0010);
    idle(1);
    rchk("capture_ns", ptc_pkg::ADDR_NS_LOW, 16'hC99C);
    rchk("capture_sec", ptc_pkg::ADDR_SEC_LOW, 16'h0005);
    rchk("capture_phase", ptc_pkg::ADDR_SUB_PHASE, 16'h0002);
    $display("test load_capture done");
    // Step forward across the second, then step back
    wr_reg(ptc_pkg::ADDR_NS_LOW, 16'h0100);
    wr_reg(ptc_pkg::ADDR_NS_HIGH, 16'h0000);
    wr_reg(ptc_pkg::ADDR_CLOCK_CONTROL, 16'h0060);
    rchk("go_visible", ptc_pkg::ADDR_CLOCK_CONTROL, 16'h0060);
    rchk("go_cleared", ptc_pkg::ADDR_CLOCK_CONTROL, 16'h0020);
    chk("step_add", {2'h0, 32'h6, 30'h09C, 32'h0}, {2'h0, live_time});
    wr_reg(ptc_pkg::ADDR_NS_LOW, 16'h0064);
    wr_reg(ptc_pkg::ADDR_CLOCK_CONTROL, 16'h0040);
    idle(1);
    chk("step_sub", {2'h0, 32'h6, 30'h038, 32'h0}, {2'h0, live_time});
    $display("test step done");
    // Running: rate zero, add, subtract, continuous off, frozen
    wr_reg(ptc_pkg::ADDR_CLOCK_CONTROL, 16'h0006);
    adv(64'h000000C8_00000000);
    wr_reg(ptc_pkg::ADDR_RATE_LOW, 16'h0100);
    adv(64'h000000C8_00000500);
    wr_reg(ptc_pkg::ADDR_RATE_HIGH, 16'hC000);
    rchk("rate_high", ptc_pkg::ADDR_RATE_HIGH, 16'h8000);
    adv(64'h000000C7_FFFFFB00);
    wr_reg(ptc_pkg::ADDR_CLOCK_CONTROL, 16'h0002);
    adv(64'h000000C8_00000000);
    wr_reg(ptc_pkg::ADDR_CLOCK_CONTROL, 16'h0000);
    adv(64'h0);
    $display("test rate done");
    // Clock reset, then phase cleared by a time word write
    wr_reg(ptc_pkg::ADDR_CLOCK_CONTROL, 16'h0001);
    idle(1);
    chk("clock_reset", 96'h0, {2'h0, live_time});
    rchk("reset_cleared", ptc_pkg::ADDR_CLOCK_CONTROL, 16'h0000);
    wr_reg(ptc_pkg::ADDR_SUB_PHASE, 16'h0003);
    rchk("phase", ptc_pkg::ADDR_SUB_PHASE, 16'h0003);
    wr_reg(ptc_pkg::ADDR_SEC_HIGH, 16'h0001);
    rchk("phase_cleared", ptc_pkg::ADDR_SUB_PHASE, 16'h0000);
    idle(1);
    $display("test reset_phase done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
